/* logic/i2cs_pkg.sv */
`default_nettype none
package i2cs_pkg;
    // seven-bit slave addresses; write byte = addr<<1, read byte = addr<<1 | 1
    localparam logic [6:0] ADDR_DEFAULT   = 7'h21;
    localparam logic [6:0] ADDR_ALTERNATE = 7'h20;
    // subaddress map
    localparam logic [7:0] SUB_REVISION   = 8'h00;
    localparam logic [7:0] SUB_DEC_ST_LO  = 8'h1E;
    localparam logic [7:0] SUB_DEC_ST_HI  = 8'h1F;
    localparam logic [7:0] SUB_SLC_ST_LO  = 8'h60;
    localparam logic [7:0] SUB_SLC_ST_MID = 8'h61;
    localparam logic [7:0] SUB_SLC_ST_HI  = 8'h62;
    localparam logic [7:0] RW_FRONT_LO    = 8'h01;
    localparam logic [7:0] RW_FRONT_HI    = 8'h19;
    localparam logic [7:0] RW_ANA_LO      = 8'h23;
    localparam logic [7:0] RW_ANA_HI      = 8'h25;
    localparam logic [7:0] RW_COMP_LO     = 8'h29;
    localparam logic [7:0] RW_AUDIO_HI    = 8'h3A;
    localparam logic [7:0] RW_SLC_LO      = 8'h40;
    localparam logic [7:0] RW_SLC_HI      = 8'h5E;
    localparam logic [7:0] RW_SCALER_LO   = 8'h80;
    localparam logic [7:0] RW_SCALER_HI   = 8'hEF;
    localparam logic [7:0] RESERVED_READ  = 8'h00;
    // revision nibble: arbitrary value
    localparam logic [3:0] REVISION_ID    = 4'h1;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    // fast mode: half bit period against clock period
    localparam int FAST_BIT_NS    = 2500;
    localparam int CLOCK_NS       = 10;
    localparam int HALF_BIT_CYC   = FAST_BIT_NS / 2 / CLOCK_NS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_RLOAD
    } i2cs_state_t;
endpackage : i2cs_pkg
`default_nettype wire

/* logic/i2cs_slave.sv */
// Notes on behaviour
// RULE1 - link accepted at fast mode, bit rates up to 400 kbit/s.
// RULE2 - write: start, write address, subaddress, data bytes, stop; all acknowledged.
// RULE3 - write address byte 42h normally, 40h when strap pin is high.
// RULE4 - read address byte 43h normally, 41h when strap pin is high.
// RULE5 - strap pin level selects the alternate address pair.
// RULE6 - combined read: subaddress write, repeated start, read address, master acks, stop.
// RULE7 - subaddress pointer increments after every data byte transferred.
// RULE8 - decoder status bytes 1Eh and 1Fh are read-only.
// RULE9 - slicer status 60h-62h read-only; slicer settings 40h-5Eh read and write.
// RULE10 - 80h to EFh fully readable and writable.
// RULE11 - subaddress 00h returns read-only revision in upper nibble, lower nibble zero.
// RULE12 - reserved subaddresses: writes acknowledged and ignored, reads return zero.
`timescale 1ns/10ps
`default_nettype none
module i2cs_slave
    import i2cs_pkg::*;
(
    input  wire logic        clock,             // system clock, 100 MHz
    input  wire logic        sys_rst,           // async reset, active high
    input  wire logic        scl_in,            // serial clock pin level
    input  wire logic        sda_in,            // serial data pin level
    output logic             sda_out,           // serial data drive level
    output logic             sda_oe,            // high while pulling data low
    input  wire logic        address_strap_pin, // high selects alternate pair
    input  wire logic [15:0] dec_status,        // decoder status, 1Fh:1Eh
    input  wire logic [23:0] slicer_status,     // slicer status, 62h:60h
    input  wire logic [7:0]  cfg_addr,          // device-side settings read address
    output logic      [7:0]  cfg_data           // settings byte at cfg_addr
);

    // ---------- input synchronisers ----------
    logic [2:0] sync1_reg, sync1_next;
    logic [2:0] sync2_reg, sync2_next;
    logic [1:0] last_reg, last_next;

    always_comb begin
        sync1_next = {address_strap_pin, sda_in, scl_in};
        sync2_next = sync1_reg;
        last_next  = sync2_reg[1:0];
    end

    // resets to idle bus levels so no false edge follows reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 3'h3;
        end else begin
            sync1_reg <= sync1_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync2_reg <= 3'h3;
        end else begin
            sync2_reg <= sync2_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last_reg <= 2'h3;
        end else begin
            last_reg <= last_next;
        end
    end

    logic scl_s;
    logic sda_s;
    logic strap_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // two-flop delay is far below the half bit period of HALF_BIT_CYC
    always_comb begin
        scl_s      = sync2_reg[0];
        sda_s      = sync2_reg[1];
        strap_s    = sync2_reg[2];
        scl_rise   = scl_s & ~last_reg[0];                  // RULE1
        scl_fall   = ~scl_s & last_reg[0];
        start_seen = scl_s & last_reg[0] & ~sda_s & last_reg[1];
        stop_seen  = scl_s & last_reg[0] & sda_s & ~last_reg[1];
    end

    i2cs_state_t state_reg, state_next;
    i2cs_state_t after_reg, after_next;
    logic [2:0]  bit_reg, bit_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  ptr_reg, ptr_next;
    logic        oe_reg, oe_next;
    logic [7:0]  rx_byte;
    logic [7:0]  rd_byte;
    logic [6:0]  my_addr;

    // ---------- register storage ----------
    function automatic logic is_writable(input logic [7:0] a);
        is_writable = (a >= RW_FRONT_LO && a <= RW_FRONT_HI)    // RULE8
                   || (a >= RW_ANA_LO && a <= RW_ANA_HI)
                   || (a >= RW_COMP_LO && a <= RW_AUDIO_HI)
                   || (a >= RW_SLC_LO && a <= RW_SLC_HI)        // RULE9
                   || (a >= RW_SCALER_LO && a <= RW_SCALER_HI); // RULE10
    endfunction : is_writable

    logic [7:0] mem [0:255];
    logic       mem_we;
    logic [7:0] mem_wd;
    logic [7:0] cfg_data_reg, cfg_data_next;

    // storage has no reset; contents undefined until written
    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[ptr_reg] <= mem_wd;
        end
    end

    // device-side port: only stored settings, everything else reads zero
    always_comb begin
        cfg_data_next = is_writable(cfg_addr) ? mem[cfg_addr] : RESERVED_READ;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_data_reg <= 8'h00;
        end else begin
            cfg_data_reg <= cfg_data_next;
        end
    end

    // ---------- link state machine ----------

    always_comb begin
        unique case (ptr_reg)
            SUB_REVISION:   rd_byte = {REVISION_ID, 4'h0};       // RULE11
            SUB_DEC_ST_LO:  rd_byte = dec_status[7:0];           // RULE8
            SUB_DEC_ST_HI:  rd_byte = dec_status[15:8];
            SUB_SLC_ST_LO:  rd_byte = slicer_status[7:0];        // RULE9
            SUB_SLC_ST_MID: rd_byte = slicer_status[15:8];
            SUB_SLC_ST_HI:  rd_byte = slicer_status[23:16];
            default:        rd_byte = is_writable(ptr_reg) ? mem[ptr_reg] : RESERVED_READ; // RULE12
        endcase
    end

    always_comb begin
        rx_byte = {shift_reg[6:0], sda_s};
        my_addr = strap_s ? ADDR_ALTERNATE : ADDR_DEFAULT;       // RULE5
    end

    // start and stop override every state
    always_comb begin
        state_next = state_reg;
        after_next = after_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        oe_next    = oe_reg;
        mem_we     = 1'b0;
        mem_wd     = rx_byte;
        if (start_seen) begin
            state_next = ST_ADDR;                                // RULE6
            bit_next   = 3'h0;
            oe_next    = 1'b0;
        end else if (stop_seen) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    oe_next = 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;
                        bit_next   = bit_reg + 3'h1;
                        if (bit_reg == LAST_BIT) begin
                            state_next = ST_ACK;                 // RULE2
                            unique case (state_reg)
                                ST_ADDR: begin
                                    if (rx_byte[7:1] != my_addr) begin
                                        state_next = ST_IDLE;    // RULE3 RULE4
                                    end
                                    after_next = rx_byte[0] ? ST_RDATA : ST_SUB;
                                end
                                ST_SUB: begin
                                    ptr_next   = rx_byte;
                                    after_next = ST_WDATA;
                                end
                                default: begin
                                    mem_we     = is_writable(ptr_reg); // RULE8 RULE9 RULE10 RULE12
                                    ptr_next   = ptr_reg + 8'h01;      // RULE7
                                    after_next = ST_WDATA;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!oe_reg) begin
                            oe_next = 1'b1;                      // RULE2
                        end else begin
                            state_next = after_reg;
                            bit_next   = 3'h0;
                            oe_next    = 1'b0;
                            if (after_reg == ST_RDATA) begin
                                shift_next = rd_byte;
                                oe_next    = ~rd_byte[7];
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_reg == LAST_BIT) begin
                            oe_next    = 1'b0;
                            state_next = ST_RACK;
                            ptr_next   = ptr_reg + 8'h01;        // RULE7
                        end else begin
                            bit_next   = bit_reg + 3'h1;
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        state_next = sda_s ? ST_IDLE : ST_RLOAD; // RULE6
                    end
                end
                ST_RLOAD: begin
                    if (scl_fall) begin
                        state_next = ST_RDATA;
                        bit_next   = 3'h0;
                        shift_next = rd_byte;
                        oe_next    = ~rd_byte[7];
                    end
                end
            endcase
        end
    end

    // pointer survives start and stop; only reset clears it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            after_reg <= ST_SUB;
        end else begin
            after_reg <= after_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bit_reg <= 3'h0;
        end else begin
            bit_reg <= bit_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= 8'h00;
        end else begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg <= 8'h00;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    // open drain: only ever pull low
    assign sda_out  = 1'b0;
    assign sda_oe   = oe_reg;
    assign cfg_data = cfg_data_reg;

endmodule : i2cs_slave
`default_nettype wire

/* tb/i2cs_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2cs_master_model (
    output logic     scl,     // serial clock, idle high
    output logic     sda_low, // high while pulling data low
    input  wire logic sda     // resolved data line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q; // quarter bit, link tick
        #125;
    endtask : q
    task automatic m_bit(input logic b, output logic r);
        sda_low = !b;
        q;
        scl = 1'b1;
        q;
        r = sda;
        q;
        scl = 1'b0;
        q;
    endtask : m_bit
    task automatic m_start;
        sda_low = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b1;
        q;
        scl = 1'b0;
        q;
    endtask : m_start
    task automatic m_stop;
        sda_low = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b0;
        q;
    endtask : m_stop
    task automatic m_wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) m_bit(d[i], r);
        m_bit(1'b1, r);
        ack = !r;
    endtask : m_wr
    task automatic m_rd(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) m_bit(1'b1, d[i]);
        m_bit(last, r);
    endtask : m_rd
endmodule : i2cs_master_model
`default_nettype wire

/* tb/i2cs_slave_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module i2cs_slave_chk (
    input wire logic        clock,             // system clock
    input wire logic        sys_rst,           // async reset
    input wire logic        scl_in,            // serial clock
    input wire logic        sda_in,            // serial data
    input wire logic        sda_out,           // data drive level
    input wire logic        sda_oe,            // data pull enable
    input wire logic        address_strap_pin, // address select
    input wire logic [15:0] dec_status,        // decoder status
    input wire logic [23:0] slicer_status,     // slicer status
    input wire logic [7:0]  cfg_addr,          // settings address
    input wire logic [7:0]  cfg_data           // settings byte
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    drive_low_a: assert property (sda_out == 1'b0) else $error("data drive not low");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
    oe_rise_a: assert property ($rose(sda_oe) |-> !$past(scl_in)) else $error("pull began too early");
    oe_bound_a: assert property (sda_oe |-> ##[1:600] !sda_oe) else $error("data held low too long");
    dec_ro_a: assert property ($past(cfg_addr) inside {8'h1E, 8'h1F} |-> cfg_data == 8'h00)
        else $error("decoder status stored");
    slc_ro_a: assert property ($past(cfg_addr) inside {[8'h60:8'h62]} |-> cfg_data == 8'h00)
        else $error("slicer status stored");
    rev_ro_a: assert property ($past(cfg_addr) == 8'h00 |-> cfg_data == 8'h00) else $error("revision stored");
    resv_ro_a: assert property ($past(cfg_addr) >= 8'hF0 |-> cfg_data == 8'h00) else $error("reserved stored");
    cover property ($rose(sda_oe));
    cover property (address_strap_pin && $rose(sda_oe));
    cover property ($past(cfg_addr) == 8'h41 && cfg_data != 8'h00);
endmodule : i2cs_slave_chk
bind i2cs_slave i2cs_slave_chk chk_i (.clock, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe,
    .address_strap_pin, .dec_status, .slicer_status, .cfg_addr, .cfg_data);
`default_nettype wire

/* tb/tb_i2cs_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_i2cs_slave;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        strap = 1'b0;
    logic [7:0]  cfg_addr = 8'h00;
    logic        sda_out, sda_oe, scl, m_low;
    logic [7:0]  cfg_data;
    logic [7:0]  rbuf [4];
    int          bad_count = 0, cmp_count = 0, cyc = 0;
    wire         sda = !(sda_oe || m_low); // pull-up line
    i2cs_master_model m (.scl(scl), .sda_low(m_low), .sda(sda));
    i2cs_slave dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_strap_pin(strap), .dec_status(16'hA55A), .slicer_status(24'h3C96E1),
        .cfg_addr(cfg_addr), .cfg_data(cfg_data));
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            close_out;
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic wb(input logic [7:0] d, input logic e);
        logic k;
        m.m_wr(d, k);
        chk("ack", {7'h00, e}, {7'h00, k});
    endtask : wb
    task automatic wr(input logic [7:0] a, s, d0, d1);
        m.m_start;
        wb(a, 1'b1);
        wb(s, 1'b1);
        wb(d0, 1'b1);
        wb(d1, 1'b1);
        m.m_stop;
    endtask : wr
    task automatic rd(input logic [7:0] a, s, input int n);
        m.m_start;
        wb(a, 1'b1);
        wb(s, 1'b1);
        m.m_start;
        wb(a | 8'h01, 1'b1);
        for (int i = 0; i < n; i++) m.m_rd(rbuf[i], i == n - 1);
        m.m_stop;
    endtask : rd
    task automatic t_rw;
        wr(8'h42, 8'h40, 8'hA5, 8'h5A);
        rd(8'h42, 8'h40, 2);
        chk("rd40", 8'hA5, rbuf[0]);
        chk("rd41", 8'h5A, rbuf[1]);
        @(posedge clock) #1 cfg_addr = 8'h41;
        repeat (2) @(posedge clock);
        #1 chk("cfg41", 8'h5A, cfg_data);
        cfg_addr = 8'h1E;
    endtask : t_rw
    task automatic t_ro;
        wr(8'h42, 8'h1E, 8'hFF, 8'hFF);
        wr(8'h42, 8'h61, 8'h00, 8'h00);
        wr(8'h42, 8'hFF, 8'h11, 8'h22);
        rd(8'h42, 8'h1E, 2);
        chk("rd1E", 8'h5A, rbuf[0]);
        chk("rd1F", 8'hA5, rbuf[1]);
        rd(8'h42, 8'h60, 3);
        chk("rd60", 8'hE1, rbuf[0]);
        chk("rd61", 8'h96, rbuf[1]);
        chk("rd62", 8'h3C, rbuf[2]);
        rd(8'h42, 8'hFF, 2);
        chk("rdFF", 8'h00, rbuf[0]);
        chk("rd00", {i2cs_pkg::REVISION_ID, 4'h0}, rbuf[1]);
    endtask : t_ro
    task automatic t_strap;
        @(posedge clock) #1 strap = 1'b1;
        repeat (5) @(posedge clock);
        m.m_start;
        wb(8'h42, 1'b0);
        m.m_stop;
        wr(8'h40, 8'hBF, 8'hC3, 8'h3C);
        rd(8'h40, 8'hBF, 2);
        chk("rdBF", 8'hC3, rbuf[0]);
        chk("rdC0", 8'h3C, rbuf[1]);
        m.m_start;
        wb(8'h43, 1'b0);
        m.m_stop;
    endtask : t_strap
    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        repeat (20) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (5) @(posedge clock);
        t_rw;
        t_ro;
        t_strap;
        close_out;
    end
endmodule : tb_i2cs_slave
`default_nettype wire
